// ---- fspr_pkg.sv ----
// Package: register map, field layout, timing and operation encodings
package fspr_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'h00;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'h04;
  localparam logic [7:0] ADDR_READ_BYTE = 8'h08;
  localparam logic [7:0] ADDR_WRITE_BYTE = 8'h0c;
  localparam logic [7:0] ADDR_PULSE_TIMING = 8'h10;
  localparam logic [7:0] ADDR_COMMAND = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Command register encodings
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_PAGE_ERASE = 3'h3;
  localparam logic [2:0] CMD_MASS_ERASE = 3'h4;
  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BOOT_ROM_BIT = 1;
  // Reset values and timing field mask
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET_10MHZ = 8'h7b;
  localparam logic [6:0] TIMING_MASK = 7'h7f;
  // Flash layout
  localparam logic [15:0] OPTION_ALIAS_ADDR = 16'hffff;
  localparam logic [15:0] OPTION_PHYS_ADDR = 16'h7fff;
  localparam logic [15:0] FLASH_START_ADDR = 16'h0000;
  localparam int BOOT_ROM_BYTES = 1024;
  // Oscillator input cycles per timing unit: UNIT_COUNT, 8 times OSC_CYCLES_PER_UNIT (128)
  localparam int OSC_CYCLES_PER_UNIT = 16;
  localparam logic [11:0] UNIT_COUNT =
    12'(OSC_CYCLES_PER_UNIT * 8);
  // Flash port request and answer
  typedef enum logic [1:0] {FSPR_OP_READ, FSPR_OP_WRITE,
    FSPR_OP_PAGE_ERASE, FSPR_OP_MASS_ERASE} fspr_op_e;
  typedef struct packed {
    logic req;
    fspr_op_e op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fspr_flash_req_s;
  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } fspr_flash_rsp_s;
endpackage

// ---- fspr_pulse_timer.sv ----
// Pulse timer: counts oscillator input edges scaled by the timing code
module fspr_pulse_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic [6:0] i_code,
  input wire logic i_osc_edge,
  // Status
  output logic o_done
);
  typedef struct packed {
    logic run;
    logic done;
    logic [6:0] units;
    logic [11:0] ticks;
  } fspr_tmr_s;
  fspr_tmr_s st_reg;
  fspr_tmr_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (i_start) begin
      st_next.run = 1'b1;
      st_next.units = (i_code == 7'h00) ? 7'h01 : i_code;
      st_next.ticks = fspr_pkg::UNIT_COUNT;
    end else if (st_reg.run && i_osc_edge) begin
      if (st_reg.ticks > 12'h001) begin
        st_next.ticks = st_reg.ticks - 12'h001;
      end else if (st_reg.units > 7'h01) begin
        st_next.units = st_reg.units - 7'h01;
        st_next.ticks = fspr_pkg::UNIT_COUNT;
      end else begin
        st_next.run = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_done = st_reg.done;
endmodule

// ---- fspr_regs.sv ----
// Self-programming registers, operation sequencer and boot selection
module fspr_regs (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Boot source and oscillator input pins
  input wire logic i_boot_flag,
  input wire logic i_osc_clock_input,
  input wire logic i_serial_cmd_valid,
  // Flash array port
  input wire fspr_pkg::fspr_flash_rsp_s i_flash_rsp,
  output fspr_pkg::fspr_flash_req_s o_flash_req,
  output logic o_pulse_active,
  // Boot control
  output logic o_boot_rom,
  output logic [15:0] o_boot_vector,
  output logic o_serial_cmd_watch
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PULSE} fspr_state_e;
  typedef struct packed {
    fspr_state_e state;
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic [7:0] read_byte;
    logic [7:0] write_byte;
    logic [6:0] timing;
    fspr_pkg::fspr_flash_req_s control;
    logic pulse;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic boot_rom;
    logic boot_taken;
    logic [15:0] vector;
    logic watch;
    logic [2:0] osc_sync;
    logic start;
  } fspr_state_s;
  fspr_state_s st_reg;
  fspr_state_s st_next;
  logic timer_done;
  logic [15:0] target;
  logic setup;

  // Byte address from the two halves, option alias folded
  function automatic logic [15:0] fspr_target(input logic [7:0] hi,
                                              input logic [7:0] lo);
    logic [15:0] a;
    a = {hi, lo};
    if (a == fspr_pkg::OPTION_ALIAS_ADDR) begin
      a = fspr_pkg::OPTION_PHYS_ADDR;
    end
    return a;
  endfunction

  assign target = fspr_target(st_reg.addr_high, st_reg.addr_low);
  assign setup = i_psel && !i_penable;

  fspr_pulse_timer u_timer (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_start(st_reg.start),
    .i_code(st_reg.timing),
    .i_osc_edge(st_reg.osc_sync[1] && !st_reg.osc_sync[2]),
    .o_done(timer_done)
  );

  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.control.req = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.osc_sync = {st_reg.osc_sync[1:0], i_osc_clock_input};
    // Boot source caught once after reset release
    if (!st_reg.boot_taken) begin
      st_next.boot_taken = 1'b1;
      st_next.boot_rom = !i_boot_flag;
      st_next.vector = fspr_pkg::FLASH_START_ADDR;
    end
    st_next.watch = st_reg.boot_rom && st_reg.boot_taken;
    // APB: no wait state, answer in first access phase cycle
    if (setup) begin
      st_next.pready = 1'b1;
      st_next.prdata = '0;
      case (i_paddr)
        fspr_pkg::ADDR_ADDR_HIGH: begin
          st_next.prdata[7:0] = st_reg.addr_high;
          if (i_pwrite) begin
            st_next.addr_high = i_pwdata[7:0];
          end
        end
        fspr_pkg::ADDR_ADDR_LOW: begin
          st_next.prdata[7:0] = st_reg.addr_low;
          if (i_pwrite) begin
            st_next.addr_low = i_pwdata[7:0];
          end
        end
        fspr_pkg::ADDR_READ_BYTE: begin
          st_next.prdata[7:0] = st_reg.read_byte;
        end
        fspr_pkg::ADDR_WRITE_BYTE: begin
          st_next.prdata[7:0] = st_reg.write_byte;
          if (i_pwrite) begin
            st_next.write_byte = i_pwdata[7:0];
          end
        end
        fspr_pkg::ADDR_PULSE_TIMING: begin
          st_next.prdata[6:0] = st_reg.timing;
          if (i_pwrite) begin
            st_next.timing = i_pwdata[6:0] & fspr_pkg::TIMING_MASK;
          end
        end
        fspr_pkg::ADDR_COMMAND: begin
          // Commands only taken while idle; internal control stays hidden
          if (i_pwrite && st_reg.state == ST_IDLE) begin
            st_next.control.addr = target;
            st_next.control.wdata = st_reg.write_byte;
            st_next.control.req = 1'b1;
            case (i_pwdata[2:0])
              fspr_pkg::CMD_READ: begin
                st_next.control.op = fspr_pkg::FSPR_OP_READ;
                st_next.state = ST_READ;
              end
              fspr_pkg::CMD_WRITE: begin
                st_next.control.op = fspr_pkg::FSPR_OP_WRITE;
                st_next.state = ST_PULSE;
                st_next.start = 1'b1;
              end
              fspr_pkg::CMD_PAGE_ERASE: begin
                st_next.control.op = fspr_pkg::FSPR_OP_PAGE_ERASE;
                st_next.state = ST_PULSE;
                st_next.start = 1'b1;
              end
              fspr_pkg::CMD_MASS_ERASE: begin
                st_next.control.op = fspr_pkg::FSPR_OP_MASS_ERASE;
                st_next.state = ST_PULSE;
                st_next.start = 1'b1;
              end
              default: begin
                st_next.control.req = 1'b0;
                st_next.pslverr = 1'b1;
              end
            endcase
          end else if (i_pwrite) begin
            st_next.pslverr = 1'b1;
          end
        end
        fspr_pkg::ADDR_STATUS: begin
          st_next.prdata[fspr_pkg::STAT_BUSY_BIT] = st_reg.state != ST_IDLE;
          st_next.prdata[fspr_pkg::STAT_BOOT_ROM_BIT] = st_reg.boot_rom;
        end
        default: begin
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    // Operation sequencing
    case (st_reg.state)
      ST_IDLE: begin
        st_next.pulse = 1'b0;
      end
      ST_READ: begin
        if (i_flash_rsp.done) begin
          st_next.read_byte = i_flash_rsp.rdata;
          st_next.state = ST_IDLE;
        end
      end
      ST_PULSE: begin
        st_next.pulse = 1'b1;
        if (timer_done) begin
          st_next.pulse = 1'b0;
          st_next.state = ST_IDLE;
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.addr_high <= fspr_pkg::ADDR_RESET;
      st_reg.addr_low <= fspr_pkg::ADDR_RESET;
      st_reg.timing <= fspr_pkg::TIMING_RESET_10MHZ[6:0];
      st_reg.boot_rom <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_prdata = st_reg.prdata;
  assign o_pready = st_reg.pready;
  assign o_pslverr = st_reg.pslverr;
  assign o_flash_req = st_reg.control;
  assign o_pulse_active = st_reg.pulse;
  assign o_boot_rom = st_reg.boot_rom;
  assign o_boot_vector = st_reg.vector;
  assign o_serial_cmd_watch = st_reg.watch;

  // Boot source follows the flag sampled after reset
  property p_boot_sel;
    @(posedge I_CLOCK) disable iff (I_RST)
    $rose(st_reg.boot_taken) |-> o_boot_rom == !$past(i_boot_flag);
  endproperty
  a_boot_sel: assert property (p_boot_sel)
    else $error("boot source does not follow flag");

  property p_vector;
    @(posedge I_CLOCK) disable iff (I_RST)
    st_reg.boot_taken && !o_boot_rom |-> o_boot_vector == 16'h0000;
  endproperty
  a_vector: assert property (p_vector)
    else $error("flash start vector wrong");

  property p_watch;
    @(posedge I_CLOCK) disable iff (I_RST)
    st_reg.boot_taken && o_boot_rom |=> o_serial_cmd_watch;
  endproperty
  a_watch: assert property (p_watch)
    else $error("serial command watch not active");

  property p_addr;
    @(posedge I_CLOCK) disable iff (I_RST)
    o_flash_req.req && o_flash_req.addr != 16'h7fff |->
      o_flash_req.addr == {$past(st_reg.addr_high), $past(st_reg.addr_low)};
  endproperty
  a_addr: assert property (p_addr)
    else $error("target address not formed from both bytes");

  property p_alias;
    @(posedge I_CLOCK) disable iff (I_RST)
    o_flash_req.req |-> o_flash_req.addr != 16'hffff;
  endproperty
  a_alias: assert property (p_alias)
    else $error("option alias not folded");

  property p_addr_reset;
    @(posedge I_CLOCK) $fell(I_RST) |->
      st_reg.addr_high == 8'h00 && st_reg.addr_low == 8'h00
      && st_reg.timing == 7'h7b;
  endproperty
  a_addr_reset: assert property (p_addr_reset)
    else $error("reset values wrong");

  sequence s_read_done;
    st_reg.state == ST_READ && i_flash_rsp.done;
  endsequence
  property p_read_byte;
    @(posedge I_CLOCK) disable iff (I_RST)
    s_read_done |=> st_reg.read_byte == $past(i_flash_rsp.rdata)
      && st_reg.state == ST_IDLE;
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("read byte not captured");

  property p_wdata;
    @(posedge I_CLOCK) disable iff (I_RST)
    o_flash_req.req |-> o_flash_req.wdata == $past(st_reg.write_byte);
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("write byte not supplied");

  sequence s_pulse_start;
    st_reg.start ##1 st_reg.state == ST_PULSE;
  endsequence
  property p_pulse;
    @(posedge I_CLOCK) disable iff (I_RST)
    s_pulse_start |-> !timer_done [*2] ##0 o_pulse_active;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse ended too early");
endmodule

// ---- fspr_regs_tb.sv ----
// Self-checking testbench for the self-programming register block
`define CHK(nm, ex, got) begin total_checks++; \
  if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module fspr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a; logic w; logic [7:0] d; logic [7:0] q; logic e;
  } fspr_row_s;
  localparam fspr_row_s ROWS [11] = '{
    {8'h00, 1'b1, 8'ha5, 8'h00, 1'b0}, {8'h00, 1'b0, 8'h00, 8'ha5, 1'b0},
    {8'h04, 1'b1, 8'h3c, 8'h00, 1'b0}, {8'h04, 1'b0, 8'h00, 8'h3c, 1'b0},
    {8'h0c, 1'b1, 8'h5a, 8'h00, 1'b0}, {8'h0c, 1'b0, 8'h00, 8'h5a, 1'b0},
    {8'h10, 1'b1, 8'hff, 8'h00, 1'b0}, {8'h10, 1'b0, 8'h00, 8'h7f, 1'b0},
    {8'h14, 1'b0, 8'h00, 8'h00, 1'b0}, {8'h1c, 1'b0, 8'h00, 8'h00, 1'b1},
    {8'h20, 1'b1, 8'h11, 8'h00, 1'b1}};
  logic clk, rst, psel, penable, pwrite, boot_flag, osc, pready, pslverr;
  logic pulse, boot_rom, watch, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] vector;
  logic [1:0] ocnt;
  fspr_pkg::fspr_flash_rsp_s rsp;
  fspr_pkg::fspr_flash_req_s req, last_req;
  int fails, total_checks, cyc, plen;

  fspr_regs u_fspr_regs (
    .I_CLOCK(clk), .I_RST(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_boot_flag(boot_flag), .i_osc_clock_input(osc),
    .i_serial_cmd_valid(1'b0), .i_flash_rsp(rsp), .o_flash_req(req),
    .o_pulse_active(pulse), .o_boot_rom(boot_rom),
    .o_boot_vector(vector), .o_serial_cmd_watch(watch));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Oscillator input at a quarter of the core clock
  always @(posedge clk) begin
    ocnt <= ocnt + 2'h1;
    osc <= ocnt[1];
    if (req.req === 1'b1) last_req <= req;
    if (pulse === 1'b1) plen <= plen + 1;
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    `CHK("pready", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_reset(input logic f);
    boot_flag <= f;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("boot rom", ~f, boot_rom)
    `CHK("cmd watch", ~f, watch)
    `CHK("vector", fspr_pkg::FLASH_START_ADDR, vector)
    apb(fspr_pkg::ADDR_STATUS, 1'b0, 8'h00);
    `CHK("status", {30'h0, ~f, 1'b0}, r)
    apb(fspr_pkg::ADDR_ADDR_HIGH, 1'b0, 8'h00);
    `CHK("addr high rst", 32'h0, r)
    apb(fspr_pkg::ADDR_ADDR_LOW, 1'b0, 8'h00);
    `CHK("addr low rst", 32'h0, r)
    apb(fspr_pkg::ADDR_PULSE_TIMING, 1'b0, 8'h00);
    `CHK("timing rst", {24'h0, fspr_pkg::TIMING_RESET_10MHZ}, r)
  endtask

  task automatic cmd(input logic [2:0] c, input logic [7:0] hi,
                     input logic [7:0] lo, input logic [15:0] ea);
    apb(fspr_pkg::ADDR_ADDR_HIGH, 1'b1, hi);
    apb(fspr_pkg::ADDR_ADDR_LOW, 1'b1, lo);
    last_req <= '0;
    plen <= 0;
    apb(fspr_pkg::ADDR_COMMAND, 1'b1, {5'h0, c});
    `CHK("cmd err", 1'b0, e)
    `CHK("req addr", ea, last_req.addr)
    `CHK("req op", c - 3'h1, {1'b0, last_req.op})
  endtask

  task automatic rd_op(input logic [7:0] hi, input logic [7:0] lo,
                       input logic [15:0] ea, input logic [7:0] d);
    cmd(fspr_pkg::CMD_READ, hi, lo, ea);
    rsp <= '{done: 1'b1, rdata: d};
    @(posedge clk);
    rsp <= '{done: 1'b0, rdata: ~d};
    repeat (2) @(posedge clk);
    apb(fspr_pkg::ADDR_READ_BYTE, 1'b0, 8'h00);
    `CHK("read byte", {24'h0, d}, r)
  endtask

  task automatic pulse_op(input logic [2:0] c, input logic [7:0] tim,
                          input logic [15:0] ea);
    int k;
    apb(fspr_pkg::ADDR_PULSE_TIMING, 1'b1, tim);
    cmd(c, ea[15:8], ea[7:0], ea);
    `CHK("req wdata", 8'ha7, last_req.wdata)
    apb(fspr_pkg::ADDR_COMMAND, 1'b1, {5'h0, fspr_pkg::CMD_READ});
    `CHK("busy refuse", 1'b1, e)
    apb(fspr_pkg::ADDR_STATUS, 1'b0, 8'h00);
    `CHK("busy", 1'b1, r[fspr_pkg::STAT_BUSY_BIT])
    k = 0;
    while (pulse !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    `CHK("pulse len", 1'b1, plen > tim * 500 && plen < tim * 524)
    apb(fspr_pkg::ADDR_STATUS, 1'b0, 8'h00);
    `CHK("idle", 1'b0, r[fspr_pkg::STAT_BUSY_BIT])
  endtask

  initial begin
    {psel, penable, pwrite, boot_flag, ocnt, osc} = '0;
    rst = 1'b1;
    {paddr, pwdata, cyc, plen, fails, total_checks} = '0;
    rsp = '0;
    last_req = '0;
    @(posedge clk);
    do_reset(1'b0);
    foreach (ROWS[i]) begin
      apb(ROWS[i].a, ROWS[i].w, ROWS[i].d);
      `CHK("err", ROWS[i].e, e)
      if (!ROWS[i].w && !ROWS[i].e) `CHK("rdata", {24'h0, ROWS[i].q}, r)
    end
    rd_op(8'h12, 8'h34, 16'h1234, 8'h96);
    rd_op(8'hff, 8'hff, fspr_pkg::OPTION_PHYS_ADDR, 8'hc3);
    apb(fspr_pkg::ADDR_WRITE_BYTE, 1'b1, 8'ha7);
    pulse_op(fspr_pkg::CMD_WRITE, 8'h01, 16'h0100);
    pulse_op(fspr_pkg::CMD_PAGE_ERASE, 8'h02, 16'h0200);
    pulse_op(fspr_pkg::CMD_MASS_ERASE, 8'h01, 16'h0000);
    apb(fspr_pkg::ADDR_COMMAND, 1'b1, 8'h07);
    `CHK("bad code", 1'b1, e)
    apb(fspr_pkg::ADDR_ADDR_HIGH, 1'b1, 8'h55);
    do_reset(1'b1);
    finish_test();
  end
endmodule
